//--- rtl/emrx_pkg.sv
// Constants and types for the receive-path control block of a multi-lane Ethernet MAC
// ****************************************************************************
// ****************************************************************************
package emrx_pkg;
   localparam int            EMRX_LANES     = 4;
   localparam int            EMRX_DEPTH     = 8;
   localparam logic [15:0]   EMRX_TINY_LEN  = 16'h0010;
   localparam logic [15:0]   EMRX_RUNT_LEN  = 16'h0040;
   localparam logic [6:0]    EMRX_LOCK_GOOD = 7'h40;
   localparam logic [4:0]    EMRX_LOCK_BAD  = 5'h10;
   localparam logic [5:0]    EMRX_WIN_LAST  = 6'h3f;
   localparam logic [7:0]    EMRX_A_STATUS  = 8'h00;
   localparam logic [7:0]    EMRX_A_MASK    = 8'h04;
   localparam logic [7:0]    EMRX_A_LANE    = 8'h08;
   localparam logic [7:0]    EMRX_A_CFG     = 8'h0c;
   localparam int            EMRX_EV_FCS    = 0;
   localparam int            EMRX_EV_OVER   = 1;
   localparam int            EMRX_EV_UNDER  = 2;
   localparam int            EMRX_EV_RUNT   = 3;
   localparam int            EMRX_EV_SFD    = 4;
   localparam int            EMRX_EV_PRE    = 5;
   localparam int            EMRX_EV_LF     = 6;
   localparam int            EMRX_EV_UNLOCK = 7;

   typedef enum logic [1:0] {
      EMRX_IDLE = 2'b00,
      EMRX_RECV = 2'b01,
      EMRX_DROP = 2'b10
   } emrx_pst_type;

   typedef struct packed {
      logic        valid;
      logic        sop;
      logic        eop;
      logic [2:0]  mty;
      logic [63:0] data;
      logic        fcs_bad;
      logic        sfd_ok;
      logic        pre_ok;
      logic [55:0] preamble;
   } emrx_in_type;

   typedef struct packed {
      logic        ena;
      logic        sop;
      logic        eop;
      logic        err;
      logic [2:0]  mty;
      logic [63:0] data;
   } emrx_client_type;

   typedef struct packed {
      logic        ignore_fcs;
      logic [14:0] max_len;
      logic [7:0]  min_len;
      logic        custom_pre;
      logic        chk_sfd;
      logic        chk_pre;
      logic        proc_lf;
   } emrx_cfg_type;

   typedef struct packed {
      logic        valid;
      logic        sop;
      logic        eop;
      logic        err;
      logic        kill;
      logic [2:0]  id;
      logic [2:0]  mty;
      logic [63:0] data;
      logic [55:0] pre;
   } emrx_slot_type;

   typedef struct packed {
      logic        lock;
      logic [6:0]  good;
      logic [4:0]  bad;
      logic [5:0]  win;
      logic [2:0]  ferr;
      logic        ferr_v;
   } emrx_lane_type;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } emrx_bus_type;
endpackage

//--- rtl/emrx_ctrl.sv
// Receive-path control: packet length policing, checks, lane lock and status registers
`timescale 1ns/1ns
module emrx_ctrl
   import emrx_pkg::*;
(
   input  wire logic                 clock,
   input  wire logic                 rst_n,
   input  wire emrx_cfg_type         ctl,
   input  wire logic                 force_resync,
   input  wire emrx_in_type          rx_in,
   input  wire logic                 lf_code,
   input  wire logic [3:0]           sh_valid,
   input  wire logic [7:0]           sh,
   input  wire emrx_bus_type         bus,
   output logic [31:0]               rdata,
   output emrx_client_type           client,
   output logic [55:0]               preamble_out,
   output logic [3:0]                block_lock,
   output logic [3:0]                ferr_valid,
   output logic [11:0]               ferr,
   output logic                      stat_bad_fcs,
   output logic                      stat_good_pkt,
   output logic                      stat_local_fault,
   output logic                      irq
);

   // ************************************************************************
   // State
   // ************************************************************************
   typedef struct packed {
      emrx_cfg_type                     cfg;
      emrx_pst_type                     pst;
      logic [15:0]                      len;
      logic [2:0]                       id;
      logic                             perr;
      emrx_slot_type [EMRX_DEPTH-1:0]   pipe;
      emrx_client_type                  out;
      logic [55:0]                      pre_out;
      emrx_lane_type [EMRX_LANES-1:0]   lane;
      logic [7:0]                       status;
      logic [7:0]                       mask;
      logic [31:0]                      rdata;
      logic                             bad_fcs;
      logic                             good;
      logic                             lf;
   } emrx_state_type;

   emrx_state_type r;
   emrx_state_type next_r;

   // Bytes carried by one word; only the last word may be partly empty
   function automatic logic [3:0] word_bytes(input logic eop, input logic [2:0] mty);
      word_bytes = eop ? (4'h8 - {1'b0, mty}) : 4'h8;
   endfunction

   // A sync header is good when its two bits differ
   function automatic logic hdr_ok(input logic [1:0] hdr);
      hdr_ok = hdr[1] ^ hdr[0];
   endfunction

   // ************************************************************************
   // Next-state logic
   // ************************************************************************
   always_comb begin
      logic          take;
      logic          start;
      logic [15:0]   base_len;
      logic [2:0]    cur_id;
      logic          perr;
      logic [15:0]   new_len;
      logic [15:0]   max16;
      logic [15:0]   kept;
      logic [3:0]    pad;
      logic          over;
      logic          last;
      logic [15:0]   final_len;
      logic          under;
      logic          fcs_err;
      logic          short_pkt;
      logic          adv;
      emrx_slot_type slot;
      emrx_slot_type leaving;
      logic [7:0]    ev;
      logic          ok;
      logic [4:0]    bad_n;
      take      = 1'b0;
      start     = 1'b0;
      base_len  = r.len;
      cur_id    = r.id;
      perr      = r.perr;
      new_len   = 16'h0000;
      max16     = {1'b0, r.cfg.max_len};
      kept      = 16'h0000;
      pad       = 4'h0;
      over      = 1'b0;
      last      = 1'b0;
      final_len = 16'h0000;
      under     = 1'b0;
      fcs_err   = 1'b0;
      short_pkt = 1'b0;
      adv       = 1'b0;
      slot      = '0;
      leaving   = r.pipe[EMRX_DEPTH-1];
      ev        = 8'h00;
      ok        = 1'b0;
      bad_n     = 5'h00;
      next_r    = r;
      next_r.rdata   = 32'h0000_0000;
      next_r.bad_fcs = 1'b0;
      next_r.good    = 1'b0;
      next_r.lf      = 1'b0;

      // Settings only change while no packet is under way
      if (r.pst == EMRX_IDLE && !rx_in.valid) begin
         next_r.cfg = ctl;
      end

      // Word acceptance and start of a new packet
      case (r.pst)
         EMRX_IDLE: begin
            start = rx_in.valid && rx_in.sop;
            take  = start;
         end
         EMRX_RECV: begin
            take = rx_in.valid;
         end
         EMRX_DROP: begin
            if (rx_in.valid && rx_in.eop) begin
               next_r.pst = EMRX_IDLE;
            end
         end
         default: begin
            next_r.pst = EMRX_IDLE;
         end
      endcase

      if (start) begin
         base_len = 16'h0000;
         cur_id   = r.id + 3'h1;
         perr     = 1'b0;
         if (r.cfg.chk_sfd && !rx_in.sfd_ok) begin
            perr           = 1'b1;
            ev[EMRX_EV_SFD] = 1'b1;
         end
         if (r.cfg.chk_pre && !rx_in.pre_ok) begin
            perr           = 1'b1;
            ev[EMRX_EV_PRE] = 1'b1;
         end
      end

      // Length policing of the accepted word
      if (take) begin
         new_len = base_len + {12'h000, word_bytes(rx_in.eop, rx_in.mty)};
         over    = (new_len > max16) || (new_len == max16 && !rx_in.eop);
         kept    = max16 - base_len;
         pad     = 4'h8 - kept[3:0];
         last    = rx_in.eop || over;
         final_len = over ? max16 : new_len;
         slot.valid = 1'b1;
         slot.sop   = start;
         slot.eop   = last;
         slot.id    = cur_id;
         slot.data  = rx_in.data;
         slot.mty   = over ? pad[2:0] : rx_in.mty;
         slot.pre   = r.cfg.custom_pre ? rx_in.preamble : 56'h0;
         if (last) begin
            under   = final_len < {8'h00, r.cfg.min_len};
            fcs_err = rx_in.eop && !over && rx_in.fcs_bad;
            // Truncated packets always end in error; FCS only when not ignored
            slot.err = over | under | perr | (fcs_err & !r.cfg.ignore_fcs);
            short_pkt = (final_len < EMRX_RUNT_LEN) || (final_len < EMRX_TINY_LEN);
            slot.kill = short_pkt;
            next_r.bad_fcs = fcs_err;
            ev[EMRX_EV_FCS]   = fcs_err;
            ev[EMRX_EV_OVER]  = over;
            ev[EMRX_EV_UNDER] = under && !short_pkt;
            ev[EMRX_EV_RUNT]  = short_pkt;
            next_r.pst = (over && !rx_in.eop) ? EMRX_DROP : EMRX_IDLE;
         end else begin
            next_r.pst = EMRX_RECV;
         end
         next_r.len  = final_len;
         next_r.id   = cur_id;
         next_r.perr = perr;
      end

      // ********************************************************************
      // Hold-back line: eight words let a short packet be pulled back whole
      // ********************************************************************
      // Stall only inside a packet with no new word, so a packet never leaves
      // before it is known to be 64 bytes or more; idle cycles drain the line.
      adv = !(r.pst == EMRX_RECV && !rx_in.valid);
      // A short packet spans eight words at most, so its earlier words are never
      // end words and never at the exit; an older packet reusing the 3-bit id
      // can only sit there, and must not be pulled back with it
      if (short_pkt) begin
         for (int i = 0; i < EMRX_DEPTH; i++) begin
            if (r.pipe[i].valid && !r.pipe[i].eop && r.pipe[i].id == cur_id) begin
               next_r.pipe[i].kill = 1'b1;
            end
         end
      end
      next_r.out.ena = 1'b0;
      next_r.out.sop = 1'b0;
      next_r.out.eop = 1'b0;
      next_r.out.err = 1'b0;
      if (adv) begin
         next_r.pipe = {next_r.pipe[EMRX_DEPTH-2:0], slot};
         if (leaving.valid && !leaving.kill) begin
            next_r.out.ena  = 1'b1;
            next_r.out.sop  = leaving.sop;
            next_r.out.eop  = leaving.eop;
            next_r.out.err  = leaving.eop && leaving.err;
            next_r.out.mty  = leaving.mty;
            next_r.out.data = leaving.data;
            next_r.good     = leaving.eop && !leaving.err;
            if (leaving.sop) begin
               next_r.pre_out = leaving.pre;
            end
         end
      end

      // Local-fault codes count only when processing is enabled
      if (r.cfg.proc_lf && lf_code) begin
         next_r.lf      = 1'b1;
         ev[EMRX_EV_LF] = 1'b1;
      end

      // ********************************************************************
      // Per-lane block lock and framing-error increments
      // ********************************************************************
      for (int i = 0; i < EMRX_LANES; i++) begin
         ok = hdr_ok(sh[2*i +: 2]);
         next_r.lane[i].ferr_v = sh_valid[i];
         next_r.lane[i].ferr   = {2'b00, sh_valid[i] && !ok};
         if (sh_valid[i]) begin
            if (!r.lane[i].lock) begin
               next_r.lane[i].good = ok ? (r.lane[i].good + 7'h01) : 7'h00;
               if (ok && (r.lane[i].good + 7'h01) == EMRX_LOCK_GOOD) begin
                  next_r.lane[i].lock = 1'b1;
                  next_r.lane[i].good = 7'h00;
                  next_r.lane[i].bad  = 5'h00;
                  next_r.lane[i].win  = 6'h00;
               end
            end else begin
               bad_n = r.lane[i].bad + {4'h0, !ok};
               next_r.lane[i].bad = bad_n;
               next_r.lane[i].win = r.lane[i].win + 6'h01;
               if (bad_n == EMRX_LOCK_BAD) begin
                  next_r.lane[i].lock = 1'b0;
                  ev[EMRX_EV_UNLOCK]  = 1'b1;
               end
               if (bad_n == EMRX_LOCK_BAD || r.lane[i].win == EMRX_WIN_LAST) begin
                  next_r.lane[i].bad = 5'h00;
                  next_r.lane[i].win = 6'h00;
               end
            end
         end
      end

      // Forced resync drops packets in flight and restarts lock hunting
      if (force_resync) begin
         next_r.pst  = EMRX_IDLE;
         next_r.pipe = '0;
         next_r.lane = '0;
         next_r.out.ena = 1'b0;
         next_r.out.sop = 1'b0;
         next_r.out.eop = 1'b0;
         next_r.out.err = 1'b0;
         next_r.good    = 1'b0; // No good pulse for a word that is not shown
         next_r.pre_out = r.pre_out;
      end

      // ********************************************************************
      // Register port
      // ********************************************************************
      // A read of status clears it, but an event in the same cycle survives
      if (bus.rd) begin
         case (bus.addr)
            EMRX_A_STATUS: next_r.rdata = {24'h000000, r.status};
            EMRX_A_MASK:   next_r.rdata = {24'h000000, r.mask};
            EMRX_A_LANE:   next_r.rdata = {28'h0000000, block_lock};
            EMRX_A_CFG:    next_r.rdata = {4'h0, r.cfg};
            default:       next_r.rdata = 32'h0000_0000;
         endcase
      end
      if (bus.rd && bus.addr == EMRX_A_STATUS) begin
         next_r.status = ev;
      end else begin
         next_r.status = r.status | ev;
      end
      if (bus.wr && bus.addr == EMRX_A_MASK) begin
         next_r.mask = bus.wdata[7:0];
      end
   end

   // Single state register; synchronous active-low reset
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // ************************************************************************
   // Outputs
   // ************************************************************************
   always_comb begin
      for (int i = 0; i < EMRX_LANES; i++) begin
         block_lock[i]     = r.lane[i].lock;
         ferr_valid[i]     = r.lane[i].ferr_v;
         ferr[3*i +: 3]    = r.lane[i].ferr;
      end
   end

   assign rdata            = r.rdata;
   assign client           = r.out;
   assign preamble_out     = r.pre_out;
   assign stat_bad_fcs     = r.bad_fcs;
   assign stat_good_pkt    = r.good;
   assign stat_local_fault = r.lf;
   assign irq              = |(r.status & r.mask); // Level while any unmasked event is held
endmodule // emrx_ctrl

//--- test/emrx_ctrl_properties.sv
// Concurrent checks on the ports of the receive-path control block
`timescale 1ns/1ns
module emrx_ctrl_properties
   import emrx_pkg::*;
(
   input wire logic            clock,
   input wire logic            rst_n,
   input wire emrx_cfg_type    ctl,
   input wire logic            force_resync,
   input wire emrx_in_type     rx_in,
   input wire logic            lf_code,
   input wire logic [3:0]      sh_valid,
   input wire logic [7:0]      sh,
   input wire emrx_bus_type    bus,
   input wire logic [31:0]     rdata,
   input wire emrx_client_type client,
   input wire logic [55:0]     preamble_out,
   input wire logic [3:0]      block_lock,
   input wire logic [3:0]      ferr_valid,
   input wire logic [11:0]     ferr,
   input wire logic            stat_bad_fcs,
   input wire logic            stat_good_pkt,
   input wire logic            stat_local_fault,
   input wire logic            irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic [11:0] ferr_exp;

   // One bad header per lane and cycle at most, so each increment is 0 or 1
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         ferr_exp[3*i +: 3] = {2'b00, sh_valid[i] && (sh[2*i] == sh[2*i+1])};
      end
   end

   // ********************************
   // Assertions
   // ********************************
   a_rdata_quiet: assert property (!$past(bus.rd) |-> rdata == 32'h0)
      else $error("read data not zero outside a read answer");
   a_lane_valid: assert property (ferr_valid == $past(sh_valid))
      else $error("framing valid strobe not one cycle after header");
   a_ferr_count: assert property (ferr == $past(ferr_exp))
      else $error("framing increment does not match bad headers");
   a_resync_unlock: assert property (force_resync |=> block_lock == 4'h0)
      else $error("block lock kept after forced resync");
   a_lock_cause: assert property (block_lock != $past(block_lock) |->
      $past(sh_valid) != 4'h0 || $past(force_resync))
      else $error("block lock changed without header or resync");
   a_err_at_eop: assert property (client.err |-> client.ena && client.eop)
      else $error("client error outside the last transfer");
   a_good_stat: assert property (stat_good_pkt |-> client.ena && client.eop && !client.err)
      else $error("good packet pulse without clean end word");
   a_pre_update: assert property ($changed(preamble_out) |-> client.ena && client.sop)
      else $error("preamble output changed away from a start word");
   a_fcs_cause: assert property (stat_bad_fcs |->
      $past(rx_in.valid && rx_in.eop && rx_in.fcs_bad))
      else $error("bad FCS pulse without bad FCS end word");
   a_lf_act: assert property (lf_code && ctl.proc_lf &&
      $past(ctl.proc_lf && !rx_in.valid) |=> stat_local_fault)
      else $error("local fault code not acted upon");
   a_lf_mute: assert property (lf_code && !ctl.proc_lf &&
      $past(!ctl.proc_lf && !rx_in.valid) |=> !stat_local_fault)
      else $error("local fault code acted upon while ignored");

   // Main scenarios reached
   c_err_eop: cover property (client.ena && client.eop && client.err);
   c_lf: cover property (stat_local_fault);
   c_lock: cover property (block_lock == 4'hf);
endmodule // emrx_ctrl_properties

bind emrx_ctrl emrx_ctrl_properties u_props (.clock, .rst_n, .ctl, .force_resync, .rx_in,
   .lf_code, .sh_valid, .sh, .bus, .rdata, .client, .preamble_out, .block_lock, .ferr_valid,
   .ferr, .stat_bad_fcs, .stat_good_pkt, .stat_local_fault, .irq);

//--- test/emrx_user_sink.sv
// Behavioural model of the user logic taking packets from the client interface
`timescale 1ns/1ns
module emrx_user_sink
   import emrx_pkg::*;
(
   input  wire logic            clock,
   input  wire logic            rst_n,
   input  wire emrx_client_type client,
   output logic [7:0]           pkt_count,
   output logic                 frame_fault
);
   logic in_pkt;

   // The interface has no back-pressure, so this sink can never stall the block
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pkt_count   <= 8'h00;
         frame_fault <= 1'b0;
         in_pkt      <= 1'b0;
      end else if (client.ena) begin
         if (client.sop == in_pkt) begin
            frame_fault <= 1'b1; // Start inside a packet or word outside one
         end
         in_pkt    <= !client.eop;
         pkt_count <= pkt_count + {7'h00, client.eop};
      end
   end
endmodule // emrx_user_sink

//--- test/tb_top.sv
// Self-checking testbench of the receive-path control block
`timescale 1ns/1ns
module tb_top
   import emrx_pkg::*;
;
   typedef struct packed {
      logic        sop, eop, err;
      logic [2:0]  mty;
      logic [63:0] data;
      logic [55:0] pre;
   } emrx_exp_type;
   logic            clock, rst_n, force_resync, lf_code, irq, rd_pend;
   logic            stat_bad_fcs, stat_good_pkt, stat_local_fault, frame_fault;
   emrx_cfg_type    ctl;
   emrx_in_type     rx_in;
   emrx_bus_type    bus;
   emrx_client_type client;
   logic [3:0]      sh_valid, block_lock, ferr_valid;
   logic [7:0]      sh, pkt_count;
   logic [31:0]     rdata;
   logic [55:0]     preamble_out;
   logic [11:0]     ferr;
   emrx_exp_type    cq[$];
   emrx_exp_type    e;
   logic [31:0]     rq[$];
   int              n_errors, n_checks, n_bad, exp_bad, exp_pkts;

   emrx_ctrl dut (.clock, .rst_n, .ctl, .force_resync, .rx_in, .lf_code, .sh_valid, .sh,
      .bus, .rdata, .client, .preamble_out, .block_lock, .ferr_valid, .ferr, .stat_bad_fcs,
      .stat_good_pkt, .stat_local_fault, .irq);
   emrx_user_sink u_sink (.clock, .rst_n, .client, .pkt_count, .frame_fault);

   // ********************************
   // Tasks
   // ********************************
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic chk_val(input string nm, input logic [63:0] ex, input logic [63:0] got);
      n_checks++;
      if (got !== ex) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // One-cycle strobe; for a read, d is the expected answer
   task automatic bus_op(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      bus <= '{addr: a, wdata: d, wr: w, rd: !w};
      if (!w) rq.push_back(d);
      @(posedge clock);
      bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
   endtask

   // Leading idle cycle lets the configuration latch before the start word
   task automatic send_pkt(input int nw, input logic [2:0] mty, input logic fb, input logic ok);
      int bytes, len;
      logic err;
      logic [55:0] pre;
      logic [63:0] d;
      emrx_exp_type x;
      @(posedge clock);
      bytes = nw * 8 - mty;
      pre = 56'({$urandom, $urandom});
      err = (bytes < ctl.min_len) | (fb & !ctl.ignore_fcs) | (!ok & (ctl.chk_sfd | ctl.chk_pre));
      exp_bad += fb;
      if (bytes >= 64) exp_pkts++;
      for (int w = 0; w < nw; w++) begin
         d = {$urandom, $urandom};
         len = (w == nw - 1) ? bytes : w * 8 + 8;
         @(posedge clock);
         rx_in <= '{valid: 1'b1, sop: w == 0, eop: w == nw - 1, mty: (w == nw - 1) ? mty : 3'h0,
            data: d, fcs_bad: fb, sfd_ok: ok, pre_ok: ok, preamble: pre};
         x = '{sop: w == 0, eop: w == nw - 1, err: err && w == nw - 1, mty: mty, data: d,
            pre: ctl.custom_pre ? pre : 56'h0};
         if (len > ctl.max_len || (len == ctl.max_len && w < nw - 1)) begin
            x.eop = 1'b1;
            x.err = 1'b1;
            x.mty = 3'(8 - (ctl.max_len - w * 8));
         end
         if (bytes >= 64) cq.push_back(x);
         if (x.eop) bytes = 0; // Words after a cut are discarded
      end
      @(posedge clock);
      rx_in.valid <= 1'b0;
      cyc(14);
   endtask

   task automatic stop_test;
      if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // ********************************
   // Clock, monitor and watchdog
   // ********************************
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // Compare each result against the oldest note when it appears
   always @(posedge clock) begin
      if (rst_n) begin
         if (rd_pend) chk_val("rdata", 64'(rq.pop_front()), 64'(rdata));
         if (client.ena) begin
            e = cq.pop_front();
            chk_val("client data", e.data, client.data);
            chk_val("client flags", 64'({e.sop, e.eop, e.err, e.eop ? e.mty : 3'h0}),
               64'({client.sop, client.eop, client.err, client.eop ? client.mty : 3'h0}));
            if (client.sop) chk_val("preamble", 64'(e.pre), 64'(preamble_out));
            if (client.eop) chk_val("good stat", 64'(!e.err), 64'(stat_good_pkt));
         end
         n_bad += stat_bad_fcs;
      end
      rd_pend <= bus.rd;
   end

   // The whole run needs about 570 cycles
   initial begin
      cyc(20000);
      n_errors++;
      stop_test;
   end

   // ********************************
   // Main sequence
   // ********************************
   initial begin
      rst_n = 1'b0;
      force_resync = 1'b0;
      lf_code = 1'b0;
      sh_valid = 4'h0;
      sh = 8'h00;
      rx_in = '0;
      bus = '0;
      ctl = '{ignore_fcs: 1'b0, max_len: 15'd1518, min_len: 8'd64, custom_pre: 1'b1,
         chk_sfd: 1'b0, chk_pre: 1'b0, proc_lf: 1'b0};
      void'($urandom(59));
      cyc(3);
      rst_n <= 1'b1;
      cyc(2);
      bus_op(1'b0, EMRX_A_CFG, 32'(ctl));
      send_pkt(8, 3'h0, 1'b0, 1'b1);
      send_pkt(9, 3'h3, 1'b1, 1'b1);
      ctl.ignore_fcs <= 1'b1;
      send_pkt(9, 3'h5, 1'b1, 1'b1);
      ctl.ignore_fcs <= 1'b0;
      send_pkt(1, 3'h0, 1'b1, 1'b1);
      send_pkt(8, 3'h1, 1'b0, 1'b1);
      ctl.min_len <= 8'h50;
      send_pkt(8, 3'h0, 1'b0, 1'b1);
      send_pkt(10, 3'h0, 1'b0, 1'b1);
      ctl.min_len <= 8'h40;
      ctl.max_len <= 15'd72;
      send_pkt(12, 3'h2, 1'b0, 1'b1);
      send_pkt(9, 3'h0, 1'b0, 1'b1);
      ctl.max_len <= 15'd1518;
      ctl.custom_pre <= 1'b0;
      send_pkt(8, 3'h0, 1'b0, 1'b1);
      for (int k = 0; k < 4; k++) begin
         ctl.chk_sfd <= k[0];
         ctl.chk_pre <= k[1];
         send_pkt(8, 3'h0, 1'b0, 1'b0);
      end
      repeat (4) send_pkt(8 + $urandom_range(4), 3'($urandom), 1'($urandom), 1'b1);
      for (int k = 0; k < 2; k++) begin
         @(posedge clock);
         ctl.proc_lf <= k[0];
         cyc(3);
         lf_code <= 1'b1;
         @(posedge clock);
         lf_code <= 1'b0;
         @(negedge clock);
         chk_val("local fault stat", 64'(k), 64'(stat_local_fault));
      end
      // Lock all lanes, then break lanes 0 and 2
      @(posedge clock);
      sh_valid <= 4'hf;
      sh <= 8'h55;
      cyc(64);
      sh_valid <= 4'h0;
      cyc(3);
      @(negedge clock);
      chk_val("block lock", 64'hf, 64'(block_lock));
      bus_op(1'b0, EMRX_A_LANE, 32'hf);
      sh_valid <= 4'h5;
      sh <= 8'h44;
      @(posedge clock);
      @(negedge clock);
      chk_val("framing err", 64'h5041, 64'({ferr_valid, ferr}));
      cyc(16);
      sh_valid <= 4'h0;
      cyc(3);
      @(negedge clock);
      chk_val("block lock", 64'ha, 64'(block_lock));
      @(posedge clock);
      force_resync <= 1'b1;
      @(posedge clock);
      force_resync <= 1'b0;
      @(negedge clock);
      chk_val("block lock", 64'h0, 64'(block_lock));
      chk_val("irq", 64'h0, 64'(irq));
      bus_op(1'b1, EMRX_A_MASK, 32'hff);
      bus_op(1'b1, EMRX_A_CFG, 32'h0);
      @(negedge clock);
      chk_val("irq", 64'h1, 64'(irq));
      bus_op(1'b0, EMRX_A_MASK, 32'hff);
      bus_op(1'b0, EMRX_A_CFG, 32'(ctl));
      bus_op(1'b0, 8'h10, 32'h0);
      bus_op(1'b0, EMRX_A_STATUS, 32'hff);
      bus_op(1'b0, EMRX_A_STATUS, 32'h0);
      @(negedge clock);
      chk_val("irq", 64'h0, 64'(irq));
      chk_val("sink packets", 64'(exp_pkts), 64'(pkt_count));
      chk_val("sink framing", 64'h0, 64'(frame_fault));
      chk_val("pending words", 64'h0, 64'(cq.size()));
      chk_val("bad fcs pulses", 64'(exp_bad), 64'(n_bad));
      stop_test;
   end
endmodule // tb_top
